//--- hdl/watchdog_reset_status.v
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "wdt_reset_defines.vh"
`default_nettype none
module watchdog_reset_status #(
  parameter OSC_DIV = 8,
  parameter RELOAD_W = 24,
  parameter GPIO_W = 46
) (
  input wire core_clk_in, // System clock, 200 MHz.
  input wire rst_n_in, // Synchronous reset, active low.
  input wire hsel_in, // AHB-Lite slave select.
  input wire [11:0] haddr_in, // AHB-Lite address.
  input wire [1:0] htrans_in, // AHB-Lite transfer type.
  input wire hwrite_in, // AHB-Lite write.
  input wire [2:0] hsize_in, // AHB-Lite size.
  input wire hready_in, // AHB-Lite bus ready.
  input wire [31:0] hwdata_in, // AHB-Lite write data.
  input wire por_in, // Power-on or brown-out event, high.
  input wire pin_reset_n_in, // External reset pin, low.
  input wire debug_pin_in, // Debug pin level.
  input wire stop_pin_wake_in, // Stop recovery by input pin change.
  input wire sleep_osc_config_in, // Stop oscillator configuration.
  input wire [15:0] pmem_data_in, // Program memory read byte pair.
  output reg [31:0] hrdata_out, // AHB-Lite read data.
  output reg hreadyout_out, // AHB-Lite ready.
  output reg hresp_out, // AHB-Lite response, always OKAY.
  output reg sys_reset_out, // Core and peripheral reset, high.
  output reg debugger_reset_out, // Debugger reset, high.
  output reg sys_clk_en_out, // System clock running.
  output reg [GPIO_W-1:0] gpio_dir_in_out, // All ones forces pins to input.
  output reg [15:0] pmem_addr_out, // Program memory fetch address.
  output reg [15:0] pc_out, // Program counter after reset.
  output reg pc_valid_out, // Program counter loaded.
  output reg timeout_pulse_out // Watchdog timed out, one cycle.
);
  // ==========================================================
  // Bus slave
  // ==========================================================
  reg dp_write_r;
  reg [11:0] dp_addr_r;
  // Only whole-word transfers are decoded, so that a narrow write can never
  // land in a register half-way through the unlock sequence.
  wire addr_ok = hsel_in && hready_in && htrans_in[1] && hsize_in == `HSIZE_WORD;
  wire wr_fire = dp_write_r;
  wire [7:0] wbyte = hwdata_in[7:0];
  reg [7:0] status_r;
  reg [7:0] control_r;
  reg [1:0] mode_r;
  wire [RELOAD_W-1:0] reload_r;
  reg [RELOAD_W-1:0] count_r;
  reg [2:0] lock_r;
  reg [2:0] lock_nxt;
  localparam L_IDLE = 3'b001;
  localparam L_KEY1 = 3'b010;
  localparam L_OPEN = 3'b100;
  reg [1:0] byte_step_r;
  wire wr_ctrl = wr_fire && dp_addr_r == `ADDR_CTRL_STATUS;
  wire wr_up = wr_fire && dp_addr_r == `ADDR_RELOAD_UPPER;
  wire wr_hi = wr_fire && dp_addr_r == `ADDR_RELOAD_HIGH;
  wire wr_lo = wr_fire && dp_addr_r == `ADDR_RELOAD_LOW;
  wire rd_status = addr_ok && !hwrite_in && haddr_in == `ADDR_CTRL_STATUS;

  // ==========================================================
  // Reset source priority and sequencer
  // ==========================================================
  localparam S_RUN = 4'b0001;
  localparam S_OSC = 4'b0010;
  localparam S_SYS = 4'b0100;
  localparam S_VEC = 4'b1000;
  reg [3:0] state_r;
  reg [7:0] osc_cnt_r;
  reg [7:0] div_r;
  reg [4:0] sys_cnt_r;
  reg dbg_only_r;
  wire in_stop = mode_r == `MODE_STOP;
  wire tmo_event = control_r[`CTL_ENABLE] && count_r == {RELOAD_W{1'b0}};
  wire pin_rst = !pin_reset_n_in;
  wire run_full = !in_stop && ((tmo_event && control_r[`CTL_TMO_RESET]) || pin_rst);
  wire stop_full = in_stop && (pin_rst || !debug_pin_in);
  wire dbg_req = !in_stop && control_r[`CTL_DBG_RESET];
  wire full_req = por_in || run_full || stop_full;
  wire any_req = full_req || dbg_req;
  // The divider only models the slower oscillator; keep OSC_DIV between 1 and 255.
  localparam [7:0] OSC_LAST = OSC_DIV - 1;
  wire osc_tick = div_r == OSC_LAST;

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_r <= S_OSC;
      osc_cnt_r <= 8'h00;
      div_r <= 8'h00;
      sys_cnt_r <= 5'h00;
      dbg_only_r <= 1'b0;
    end else begin
      div_r <= osc_tick ? 8'h00 : div_r + 8'h01;
      case (state_r)
        S_RUN: begin
          if (any_req) begin
            state_r <= S_OSC;
            osc_cnt_r <= 8'h00;
            dbg_only_r <= !full_req;
          end
        end
        S_OSC: begin
          // A power-on during the count restarts it, so a supply that comes
          // back in mid-sequence still gets the full hold.
          if (por_in) begin
            osc_cnt_r <= 8'h00;
            dbg_only_r <= 1'b0;
          end else if (osc_tick) begin
            if (osc_cnt_r == `OSC_HOLD_CYCLES - 1) begin
              state_r <= S_SYS;
              sys_cnt_r <= 5'h00;
            end else begin
              osc_cnt_r <= osc_cnt_r + 8'h01;
            end
          end
        end
        S_SYS: begin
          if (sys_cnt_r == `SYS_HOLD_CYCLES - 1) begin
            state_r <= S_VEC;
          end else begin
            sys_cnt_r <= sys_cnt_r + 5'h01;
          end
        end
        S_VEC: begin
          state_r <= S_RUN;
        end
        default: begin
          state_r <= S_OSC;
        end
      endcase
    end
  end

  // ==========================================================
  // Reset outputs, vector fetch
  // ==========================================================
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sys_reset_out <= 1'b1;
      debugger_reset_out <= 1'b1;
      sys_clk_en_out <= 1'b0;
      gpio_dir_in_out <= {GPIO_W{1'b1}};
      pmem_addr_out <= `VEC_ADDR_HI;
      pc_out <= 16'h0000;
      pc_valid_out <= 1'b0;
    end else begin
      sys_reset_out <= state_r != S_RUN && state_r != S_VEC;
      debugger_reset_out <= state_r == S_OSC && !dbg_only_r;
      sys_clk_en_out <= state_r != S_OSC;
      // Pins become inputs at reset start.
      if (state_r == S_OSC || (state_r == S_RUN && any_req)) begin
        gpio_dir_in_out <= {GPIO_W{1'b1}};
      end
      // Vector bytes form the program counter.
      pmem_addr_out <= `VEC_ADDR_HI;
      if (state_r == S_VEC) begin
        pc_out <= pmem_data_in;
        pc_valid_out <= 1'b1;
      end else if (state_r != S_RUN) begin
        pc_valid_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Watchdog counter and reload lock
  // ==========================================================
  always @* begin
    lock_nxt = lock_r;
    if (wr_fire) begin
      case (lock_r)
        L_IDLE: lock_nxt = (wr_ctrl && wbyte == `UNLOCK_KEY1) ? L_KEY1 : L_IDLE;
        L_KEY1: lock_nxt = (wr_ctrl && wbyte == `UNLOCK_KEY2) ? L_OPEN : L_IDLE;
        L_OPEN: begin
          if (byte_step_r == 2'h0 && wr_up) begin
            lock_nxt = L_OPEN;
          end else if (byte_step_r == 2'h1 && wr_hi) begin
            lock_nxt = L_OPEN;
          end else if (byte_step_r == 2'h2 && wr_lo) begin
            lock_nxt = L_IDLE;
          end else begin
            // Anything out of order drops the unlock as well.
            lock_nxt = L_IDLE;
          end
        end
        default: lock_nxt = L_IDLE;
      endcase
    end
  end

  wire refresh = wr_fire && dp_addr_r == `ADDR_CONTROL && wbyte[`CTL_REFRESH];
  wire enable_rise = wr_fire && dp_addr_r == `ADDR_CONTROL && wbyte[`CTL_ENABLE] &&
    !control_r[`CTL_ENABLE];

  // A debugger-only reset keeps the watchdog setup, so software that started it
  // does not have to unlock and reload it again.
  wire hold_regs = state_r != S_RUN && !dbg_only_r;

  genvar gi;
  generate
    for (gi = 0; gi < `RELOAD_BYTES; gi = gi + 1) begin : g_reload
      // Entry 2 is the upper byte and must be written first.
      localparam [1:0] STEP = `RELOAD_BYTES - 1 - gi;
      localparam [11:0] ADDR = `ADDR_RELOAD_UPPER + `REG_STRIDE * (`RELOAD_BYTES - 1 - gi);
      wire wr_here = wr_fire && dp_addr_r == ADDR;
      reg [7:0] byte_r;
      always @(posedge core_clk_in) begin
        if (!rst_n_in || hold_regs) begin
          byte_r <= `RELOAD_RESET_BYTE;
        end else if (lock_r == L_OPEN && byte_step_r == STEP && wr_here) begin
          byte_r <= wbyte;
        end
      end
    end
  endgenerate
  assign reload_r = {g_reload[2].byte_r, g_reload[1].byte_r, g_reload[0].byte_r};

  always @(posedge core_clk_in) begin
    if (!rst_n_in || hold_regs) begin
      lock_r <= L_IDLE;
      byte_step_r <= 2'h0;
      count_r <= `RELOAD_RESET;
      control_r <= 8'h00;
      mode_r <= `MODE_NORMAL;
      timeout_pulse_out <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
      timeout_pulse_out <= tmo_event;
      // Only bus writes move the reload step on; the idle cycles that a master
      // leaves between the unlock writes must not use up a step.
      if (wr_fire) begin
        if (lock_r == L_OPEN && lock_nxt == L_OPEN) begin
          byte_step_r <= byte_step_r + 2'h1;
        end else begin
          byte_step_r <= 2'h0;
        end
      end
      if (wr_fire && dp_addr_r == `ADDR_CONTROL) begin
        control_r <= {4'h0, wbyte[`CTL_DBG_RESET], 1'b0, wbyte[`CTL_TMO_RESET:`CTL_ENABLE]};
      end else if (state_r != S_RUN) begin
        control_r[`CTL_DBG_RESET] <= 1'b0;
      end
      if (wr_fire && dp_addr_r == `ADDR_MODE) begin
        mode_r <= wbyte[1:0];
      end else if (in_stop && (tmo_event || stop_pin_wake_in)) begin
        // Any stop recovery returns the block to normal operation.
        mode_r <= `MODE_NORMAL;
      end
      // Reload on enable or refresh.
      // A timeout reloads as well, so one without reset does not fire every tick.
      if (enable_rise || refresh || tmo_event) begin
        count_r <= reload_r;
      end else if (control_r[`CTL_ENABLE] && osc_tick) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // ==========================================================
  // Status flags
  // ==========================================================
  wire stop_tmo = in_stop && tmo_event;
  wire stop_pin = in_stop && stop_pin_wake_in;
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      status_r <= `STATUS_RESET;
    end else begin
      // Read clears upper flags; events set afterwards win.
      if (rd_status) begin
        status_r[`FLAGS_HI:`FLAGS_LO] <= 4'h0;
      end
      // Reserved bits zero, config bit live.
      status_r[`RSVD_HI:`RSVD_LO] <= 3'h0;
      status_r[`BIT_SLEEPCFG] <= sleep_osc_config_in;
      if (por_in) begin
        status_r[`BIT_POR] <= 1'b1;
      end else if (stop_tmo) begin
        status_r[`BIT_POR] <= 1'b0;
      end
      if (por_in) begin
        status_r[`BIT_STOPREC] <= 1'b0;
      end else if (stop_tmo || stop_pin) begin
        status_r[`BIT_STOPREC] <= 1'b1;
      end else if (tmo_event) begin
        status_r[`BIT_STOPREC] <= 1'b0;
      end
      if (por_in) begin
        status_r[`BIT_TIMEOUT] <= 1'b0;
      end else if (tmo_event) begin
        status_r[`BIT_TIMEOUT] <= 1'b1;
      end else if (stop_pin) begin
        status_r[`BIT_TIMEOUT] <= 1'b0;
      end
      if (por_in) begin
        status_r[`BIT_PINRST] <= 1'b0;
      end else if (pin_rst) begin
        status_r[`BIT_PINRST] <= 1'b1;
      end else if (stop_pin) begin
        status_r[`BIT_PINRST] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Bus phases and read mux
  // ==========================================================
  // Reads are answered with zero wait states; the mux looks at the address phase.
  // Ready never drops: every register answers in one cycle, so no wait states
  // are needed and the read data stands for exactly one data phase.
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      dp_write_r <= 1'b0;
      dp_addr_r <= 12'h000;
      hrdata_out <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      dp_write_r <= addr_ok && hwrite_in;
      dp_addr_r <= haddr_in;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      hrdata_out <= 32'h00000000;
      if (addr_ok && !hwrite_in) begin
        case (haddr_in)
          `ADDR_CTRL_STATUS: hrdata_out <= {24'h000000, status_r};
          `ADDR_RELOAD_UPPER: hrdata_out <= {24'h000000, count_r[23:16]};
          `ADDR_RELOAD_HIGH: hrdata_out <= {24'h000000, count_r[15:8]};
          `ADDR_RELOAD_LOW: hrdata_out <= {24'h000000, count_r[7:0]};
          `ADDR_CONTROL: hrdata_out <= {24'h000000, control_r};
          `ADDR_MODE: hrdata_out <= {30'h00000000, mode_r};
          default: hrdata_out <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- include/wdt_reset_defines.vh
`ifndef WDT_RESET_DEFINES_VH
`define WDT_RESET_DEFINES_VH
// Register byte addresses; the word at each offset holds an 8-bit register in bits 7:0, except the 2-bit mode register in bits 1:0.
`define ADDR_CTRL_STATUS 12'hFF0
`define ADDR_RELOAD_UPPER 12'hFF4
`define ADDR_RELOAD_HIGH 12'hFF8
`define ADDR_RELOAD_LOW 12'hFFC
`define ADDR_CONTROL 12'hFE0
`define ADDR_MODE 12'hFE4
// Unlock keys.
`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'hAA
// Status field positions.
`define BIT_POR 7
`define BIT_STOPREC 6
`define BIT_TIMEOUT 5
`define BIT_PINRST 4
`define BIT_SLEEPCFG 0
// Control register bits.
`define CTL_ENABLE 0
`define CTL_TMO_RESET 1
`define CTL_REFRESH 2
`define CTL_DBG_RESET 3
// Mode register encoding.
`define MODE_NORMAL 2'h0
`define MODE_HALT 2'h1
`define MODE_STOP 2'h2
// Reset sequence counts.
`define OSC_HOLD_CYCLES 66
`define SYS_HOLD_CYCLES 16
// Reset vector location.
`define VEC_ADDR_HI 16'h0002
`define VEC_ADDR_LO 16'h0003
// Reload reset value.
`define RELOAD_RESET 24'hFFFFFF
`define RELOAD_RESET_BYTE 8'hFF
`define RELOAD_BYTES 3
`define REG_STRIDE 4
// Status reset value and field spans.
`define STATUS_RESET 8'h80
`define FLAGS_HI 7
`define FLAGS_LO 4
`define RSVD_HI 3
`define RSVD_LO 1
// Only whole-word bus transfers are decoded.
`define HSIZE_WORD 3'h2
`endif

//--- verif/watchdog_reset_status_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module watchdog_reset_status_assertions #(
  parameter OSC_DIV = 8,
  parameter GPIO_W = 46
) (
  input wire core_clk_in, // System clock.
  input wire rst_n_in, // Synchronous reset, low.
  input wire hsel_in, // Slave select.
  input wire [11:0] haddr_in, // Address.
  input wire [1:0] htrans_in, // Transfer type.
  input wire hwrite_in, // Write.
  input wire hready_in, // Bus ready.
  input wire [31:0] hrdata_out, // Read data.
  input wire por_in, // Power-on event.
  input wire pin_reset_n_in, // Reset pin.
  input wire sleep_osc_config_in, // Stop oscillator setting.
  input wire sys_reset_out, // System reset.
  input wire debugger_reset_out, // Debugger reset.
  input wire sys_clk_en_out, // System clock on.
  input wire [GPIO_W-1:0] gpio_dir_in_out, // Pin directions.
  input wire [15:0] pmem_addr_out, // Fetch address.
  input wire pc_valid_out // Program counter loaded.
);
  // The oscillator phase is free, so the hold count is allowed a little slack.
  localparam int OSC_MIN = 65 * OSC_DIV;
  localparam int OSC_MAX = 66 * OSC_DIV + 8;
  logic st_q;
  int hold_cnt;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  always @(posedge core_clk_in) begin
    st_q <= rst_n_in && hsel_in && hready_in && htrans_in[1] && !hwrite_in && haddr_in == 12'hFF0;
    if (!rst_n_in || !sys_reset_out || sys_clk_en_out) hold_cnt <= 0;
    else hold_cnt <= hold_cnt + 1;
  end
  a_reset_state: assert property ($rose(rst_n_in) |->
    sys_reset_out && (&gpio_dir_in_out) && !sys_clk_en_out) else $error("reset state wrong");
  a_clk_hold: assert property ($rose(sys_clk_en_out) |->
    sys_reset_out[*8] ##1 sys_reset_out[*8] ##[1:4] !sys_reset_out) else $error("clock hold wrong");
  a_osc_count: assert property ($rose(sys_clk_en_out) |->
    hold_cnt >= OSC_MIN && hold_cnt <= OSC_MAX) else $error("oscillator hold count wrong");
  a_vector_addr: assert property (pc_valid_out |-> pmem_addr_out == 16'h0002)
    else $error("vector address wrong");
  a_status_layout: assert property (st_q |-> hrdata_out[31:8] == 24'h0 &&
    hrdata_out[3:1] == 3'h0 && hrdata_out[0] == sleep_osc_config_in) else $error("status layout");
  a_por_wins: assert property (por_in |-> ##[1:3] (sys_reset_out && debugger_reset_out))
    else $error("power-on reset missed");
  a_pin_reset: assert property (!pin_reset_n_in |-> ##[1:3] sys_reset_out)
    else $error("pin reset missed");
  a_gpio_input: assert property ($rose(sys_reset_out) |-> ##[0:1] (&gpio_dir_in_out))
    else $error("pins not input");
  a_dbg_spared: assert property (debugger_reset_out |-> sys_reset_out)
    else $error("debugger reset alone");
endmodule
`default_nettype wire

//--- verif/test_watchdog_reset_status.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdt_reset_defines.vh"
module test_watchdog_reset_status;
  logic core_clk_in, rst_n_in, hsel_in, hwrite_in, por_in, pin_reset_n_in, debug_pin_in;
  logic stop_pin_wake_in, sleep_osc_config_in;
  logic [11:0] haddr_in;
  logic [1:0] htrans_in;
  logic [2:0] hsize_in;
  logic [31:0] hwdata_in, rd;
  logic [15:0] pmem_data_in;
  wire [31:0] hrdata_out;
  wire hreadyout_out, hresp_out, sys_reset_out, debugger_reset_out, sys_clk_en_out;
  wire pc_valid_out, timeout_pulse_out, hready_in;
  wire [45:0] gpio_dir_in_out;
  wire [15:0] pmem_addr_out, pc_out;
  int mismatches, total_checks, n;
  logic tmo_seen;
  assign hready_in = hreadyout_out;
  always @(posedge core_clk_in) tmo_seen <= rst_n_in && (tmo_seen || timeout_pulse_out === 1'b1);
  watchdog_reset_status #(.OSC_DIV(1)) u_watchdog_reset_status (.core_clk_in, .rst_n_in,
    .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hready_in, .hwdata_in, .por_in,
    .pin_reset_n_in, .debug_pin_in, .stop_pin_wake_in, .sleep_osc_config_in, .pmem_data_in,
    .hrdata_out, .hreadyout_out, .hresp_out, .sys_reset_out, .debugger_reset_out,
    .sys_clk_en_out, .gpio_dir_in_out, .pmem_addr_out, .pc_out, .pc_valid_out,
    .timeout_pulse_out);
  // ==========================================
  // Shared tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wt;
    int k;
    k = 0;
    do begin
      @(posedge core_clk_in);
      k++;
    end while (hreadyout_out !== 1'b1 && k < 20);
    if (k >= 20) begin
      mismatches++;
      $display("[ERR] %0t bus wait ran out", $time);
      finish_test;
    end
  endtask
  // Read data and ready are sampled before this edge's updates land.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    hwrite_in <= w;
    haddr_in <= a;
    wt();
    htrans_in <= 2'h0;
    hwdata_in <= d;
    wt();
    rd = hrdata_out;
    chk(hresp_out, 32'h0, "response not okay");
  endtask
  task automatic rs(input logic [7:0] e, input string m);
    bus(1'b0, `ADDR_CTRL_STATUS, 32'h0);
    chk(rd, {24'h0, e}, m);
  endtask
  task automatic unl(input logic [23:0] v);
    bus(1'b1, `ADDR_CTRL_STATUS, {24'h0, `UNLOCK_KEY1});
    bus(1'b1, `ADDR_CTRL_STATUS, {24'h0, `UNLOCK_KEY2});
    bus(1'b1, `ADDR_RELOAD_UPPER, {24'h0, v[23:16]});
    bus(1'b1, `ADDR_RELOAD_HIGH, {24'h0, v[15:8]});
    bus(1'b1, `ADDR_RELOAD_LOW, {24'h0, v[7:0]});
  endtask
  task automatic wsr(input logic v, input int lim);
    n = 0;
    while (sys_reset_out !== v && n < lim) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      $display("[ERR] %0t reset wait ran out", $time);
      finish_test;
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  initial begin
    {rst_n_in, hsel_in, hwrite_in, por_in, stop_pin_wake_in, haddr_in, htrans_in} = '0;
    {pin_reset_n_in, debug_pin_in, sleep_osc_config_in} = 3'h7;
    hsize_in = 3'h2;
    hwdata_in = 32'h0;
    pmem_data_in = 16'h1234;
    repeat (6) @(posedge core_clk_in);
    chk({sys_reset_out, sys_clk_en_out, &gpio_dir_in_out}, 32'h5, "reset state");
    rst_n_in <= 1'b1;
    wsr(1'b0, 2000);
    chk(n >= 82 && n <= 95, 32'h1, "hold length");
    chk({pc_out, pmem_addr_out}, 32'h12340002, "vector");
    chk({pc_valid_out, sys_clk_en_out}, 32'h3, "vector loaded, clock on");
    rs(8'h81, "status after power-on");
    rs(8'h01, "status cleared");
    $display("test power-on done");
    pin_reset_n_in <= 1'b0;
    wsr(1'b1, 10);
    pin_reset_n_in <= 1'b1;
    wsr(1'b0, 2000);
    unl(24'h12FF00);
    rs(8'h11, "pin flag kept by keys");
    bus(1'b1, `ADDR_CONTROL, 32'h1);
    bus(1'b0, `ADDR_RELOAD_UPPER, 32'h0);
    chk(rd, 32'h12, "reload loaded");
    bus(1'b1, `ADDR_CTRL_STATUS, 32'h55);
    bus(1'b1, `ADDR_MODE, 32'h0);
    bus(1'b1, `ADDR_CTRL_STATUS, 32'hAA);
    for (int i = 0; i < 6; i++) bus(1'b1, 12'hFF4 + 12'(4 * (i % 3)), 32'h34);
    bus(1'b1, `ADDR_CONTROL, 32'h5);
    bus(1'b0, `ADDR_RELOAD_UPPER, 32'h0);
    chk(rd, 32'h12, "locked reload kept");
    $display("test unlock done");
    chk(tmo_seen, 32'h0, "no early timeout");
    bus(1'b1, `ADDR_MODE, {30'h0, `MODE_HALT});
    unl(24'h000020);
    bus(1'b1, `ADDR_CONTROL, 32'h7);
    wsr(1'b1, 400);
    chk(tmo_seen, 32'h1, "timeout pulse");
    wsr(1'b0, 2000);
    rs(8'h21, "timeout flag");
    bus(1'b0, `ADDR_RELOAD_UPPER, 32'h0);
    chk(rd, 32'hFF, "reload reset value");
    bus(1'b1, `ADDR_CONTROL, 32'h8);
    wsr(1'b1, 10);
    chk(debugger_reset_out, 32'h0, "debugger spared");
    wsr(1'b0, 2000);
    rs(8'h01, "no flag from debugger reset");
    $display("test timeout done");
    por_in <= 1'b1;
    pin_reset_n_in <= 1'b0;
    wsr(1'b1, 10);
    por_in <= 1'b0;
    pin_reset_n_in <= 1'b1;
    wsr(1'b0, 2000);
    rs(8'h81, "power-on wins");
    bus(1'b1, `ADDR_MODE, {30'h0, `MODE_STOP});
    stop_pin_wake_in <= 1'b1;
    @(posedge core_clk_in);
    stop_pin_wake_in <= 1'b0;
    wsr(1'b0, 2000);
    rs(8'h41, "stop recovery flag");
    bus(1'b1, `ADDR_MODE, {30'h0, `MODE_STOP});
    debug_pin_in <= 1'b0;
    wsr(1'b1, 10);
    debug_pin_in <= 1'b1;
    wsr(1'b0, 2000);
    bus(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    $display("test stop done");
    finish_test;
  end
endmodule
bind watchdog_reset_status watchdog_reset_status_assertions #(.OSC_DIV(OSC_DIV),
  .GPIO_W(GPIO_W)) u_watchdog_reset_status_assertions (.core_clk_in, .rst_n_in, .hsel_in,
  .haddr_in, .htrans_in, .hwrite_in, .hready_in, .hrdata_out, .por_in, .pin_reset_n_in,
  .sleep_osc_config_in, .sys_reset_out, .debugger_reset_out, .sys_clk_en_out,
  .gpio_dir_in_out, .pmem_addr_out, .pc_valid_out);
`default_nettype wire
